// [shared/op_decoder_defines.vh]
// Purpose: constants for the control and indirect opcode decoder
// Assumes: 14-bit instruction words, 8-bit data
// Notes: opcode patterns compared after masking
`ifndef OP_DECODER_DEFINES_VH
`define OP_DECODER_DEFINES_VH
`define OPW_BRANCH_W 14'h000B
`define OPW_CALL_W 14'h000A
`define OPW_RETURN 14'h0008
`define OPW_RET_INT 14'h0009
`define OPW_IDLE 14'h0000
`define OPW_RESET 14'h0001
`define OPW_OPTION 14'h0062
`define OPW_SLEEP 14'h0063
`define OPW_WDT_CLEAR 14'h0064
`define OPM_DIR 14'h3FF8
`define OPW_DIR 14'h0060
`define OPM_MOD 14'h3FF0
`define OPW_MOD 14'h0010
`define OPM_LIT 14'h3F00
`define OPW_RET_LIT 14'h3400
`define OPW_AND_LIT 14'h3900
`define OPW_ADD_LIT 14'h3E00
`define OPM_PTR_ADD 14'h3F80
`define OPW_PTR_ADD 14'h3100
`define OPM_IDX 14'h3F00
`define OPW_IDX 14'h3F00
`define OPM_REL 14'h3E00
`define OPW_REL 14'h3200
`define OPM_CALL 14'h3800
`define OPW_CALL 14'h2000
`define OPW_GOTO 14'h2800
`define OPW_AND_REG 14'h0500
`define IND0_ADDR 7'h00
`define IND1_ADDR 7'h01
`define STAT_C 0
`define STAT_DC 1
`define STAT_Z 2
`define STAT_PWRDN 3
`define STAT_TMOUT 4
`define STATUS_RESET 8'h18
`define OPTION_RESET 8'hFF
`define PC_RESET 15'h0000
`define SP_RESET 4'h0
`endif

// [hdl/control_and_indirect_op_decoder.v]
// Purpose: decode and execute control, inherent, pointer and indexed opcodes
// Assumes: one instruction word per cycle, data memory answers combinationally
// Notes: file register and data memory reached through plain ports
`timescale 1ns/100ps
`include "op_decoder_defines.vh"
module control_and_indirect_op_decoder
#(
   parameter PC_W = 15,
   parameter STACK_DEPTH = 16
)
(
   // clock and reset
   input wire core_clk,
   input wire reset_n,
   // program memory
   output reg [PC_W-1:0] fetch_addr,
   input wire [13:0] instr_word,
   // data memory
   output reg [15:0] data_addr,
   output reg [7:0] data_wdata,
   output reg data_we,
   input wire [7:0] data_rdata,
   // file register window
   output reg [6:0] file_addr,
   output reg [7:0] file_wdata,
   output reg file_we,
   input wire [7:0] file_rdata,
   // core state
   output reg [7:0] working_q,
   output reg [7:0] status_q,
   output reg [7:0] option_q,
   output reg [7:0] dir_sel_q,
   output reg [7:0] dir_data_q,
   output reg dir_we_q,
   output reg standby_q,
   output reg soft_reset_q,
   output reg [15:0] pointer0_q,
   output reg [15:0] pointer1_q,
   output reg stall_q
);
   reg [PC_W-1:0] pc_q;
   reg [PC_W-1:0] stack_q [0:STACK_DEPTH-1];
   reg [3:0] sp_q;
   reg [1:0] wait_q;
   reg [13:0] op;
   reg [PC_W-1:0] pc_next;
   reg [PC_W-1:0] pc_inc;
   reg flush;
   reg push;
   reg pop;
   reg [7:0] w_d;
   reg [7:0] status_d;
   reg [15:0] p0_d;
   reg [15:0] p1_d;
   reg [15:0] psel;
   reg [15:0] padj;
   reg extra;
   reg [8:0] sum9;
   reg [4:0] sum5;
   reg [7:0] andv;
   integer i;

   always @*
   begin
      op = instr_word;
      pc_inc = pc_q + {{(PC_W-1){1'b0}}, 1'b1};
      pc_next = pc_inc;
      flush = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      w_d = working_q;
      status_d = status_q;
      p0_d = pointer0_q;
      p1_d = pointer1_q;
      psel = op[6] ? pointer1_q : pointer0_q;
      padj = psel;
      extra = 1'b0;
      data_addr = psel;
      // data writes always carry W; only data_we gates them
      data_wdata = working_q;
      data_we = 1'b0;
      file_addr = op[6:0];
      file_wdata = 8'h00;
      file_we = 1'b0;
      sum9 = 9'h000;
      sum5 = 5'h00;
      andv = 8'h00;
      if (wait_q == 2'b00)
      begin
         if (op == `OPW_BRANCH_W)
         begin
            pc_next = pc_inc + {{(PC_W-8){1'b0}}, working_q};
            flush = 1'b1;
         end
         else if (op == `OPW_CALL_W)
         begin
            push = 1'b1;
            // target keeps the upper pc bits
            pc_next = {pc_q[PC_W-1:8], working_q};
            flush = 1'b1;
         end
         // no interrupt logic here, so both returns share the pop
         else if (op == `OPW_RETURN || op == `OPW_RET_INT)
         begin
            pop = 1'b1;
            pc_next = stack_q[sp_q - 4'h1];
            flush = 1'b1;
         end
         else if ((op & `OPM_LIT) == `OPW_RET_LIT)
         begin
            w_d = op[7:0];
            pop = 1'b1;
            pc_next = stack_q[sp_q - 4'h1];
            flush = 1'b1;
         end
         else if ((op & `OPM_REL) == `OPW_REL)
         begin
            pc_next = pc_inc + {{(PC_W-9){op[8]}}, op[8:0]};
            flush = 1'b1;
         end
         else if ((op & `OPM_CALL) == `OPW_CALL || (op & `OPM_CALL) == `OPW_GOTO)
         begin
            push = ~op[11];
            pc_next = {pc_q[PC_W-1:11], op[10:0]};
            flush = 1'b1;
         end
         else if (op == `OPW_SLEEP || op == `OPW_WDT_CLEAR)
         begin
            status_d[`STAT_TMOUT] = 1'b1;
            status_d[`STAT_PWRDN] = (op == `OPW_WDT_CLEAR);
         end
         else if ((op & `OPM_PTR_ADD) == `OPW_PTR_ADD)
         begin
            // signed add with wrap
            // sums are 16 bits wide, so the wrap costs nothing
            padj = psel + {{10{op[5]}}, op[5:0]};
            if (op[6])
               p1_d = padj;
            else
               p0_d = padj;
         end
         else if ((op & `OPM_MOD) == `OPW_MOD)
         begin
            // pointer choice sits in bit 2 here, not bit 6
            psel = op[2] ? pointer1_q : pointer0_q;
            padj = op[0] ? psel - 16'h0001 : psel + 16'h0001;
            data_addr = op[1] ? psel : padj;
            if (op[2])
               p1_d = padj;
            else
               p0_d = padj;
            if (op[3])
               data_we = 1'b1;
            else
            begin
               w_d = data_rdata;
               status_d[`STAT_Z] = (data_rdata == 8'h00);
            end
            extra = data_addr[15];
         end
         else if ((op & `OPM_IDX) == `OPW_IDX)
         begin
            data_addr = psel + {{10{op[5]}}, op[5:0]};
            extra = data_addr[15];
            if (op[7])
               data_we = 1'b1;
            else
            begin
               w_d = data_rdata;
               status_d[`STAT_Z] = (data_rdata == 8'h00);
            end
         end
         else if ((op & `OPM_LIT) == `OPW_AND_LIT)
         begin
            w_d = working_q & op[7:0];
            status_d[`STAT_Z] = (w_d == 8'h00);
         end
         else if ((op & `OPM_LIT) == `OPW_ADD_LIT)
         begin
            sum9 = {1'b0, working_q} + {1'b0, op[7:0]};
            sum5 = {1'b0, working_q[3:0]} + {1'b0, op[3:0]};
            w_d = sum9[7:0];
            status_d[`STAT_C] = sum9[8];
            status_d[`STAT_DC] = sum5[4];
            status_d[`STAT_Z] = (sum9[7:0] == 8'h00);
         end
         else if ((op & `OPM_LIT) == `OPW_AND_REG)
         begin
            andv = working_q & file_rdata;
            status_d[`STAT_Z] = (andv == 8'h00);
            if (op[7])
            begin
               file_wdata = andv;
               file_we = 1'b1;
            end
            else
               w_d = andv;
            extra = (op[6:0] == `IND0_ADDR && pointer0_q[15]) ||
               (op[6:0] == `IND1_ADDR && pointer1_q[15]);
         end
      end
   end

   always @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         pc_q <= `PC_RESET;
         fetch_addr <= `PC_RESET;
         sp_q <= `SP_RESET;
         wait_q <= 2'b00;
         working_q <= 8'h00;
         status_q <= `STATUS_RESET;
         option_q <= `OPTION_RESET;
         dir_sel_q <= 8'h00;
         dir_data_q <= 8'h00;
         dir_we_q <= 1'b0;
         standby_q <= 1'b0;
         soft_reset_q <= 1'b0;
         pointer0_q <= 16'h0000;
         pointer1_q <= 16'h0000;
         stall_q <= 1'b0;
         for (i = 0; i < STACK_DEPTH; i = i + 1)
            stack_q[i] <= {PC_W{1'b0}};
      end
      else
      begin
         dir_we_q <= 1'b0;
         soft_reset_q <= 1'b0;
         if (wait_q != 2'b00)
         begin
            wait_q <= wait_q - 2'b01;
            stall_q <= (wait_q != 2'b01);
         end
         else
         begin
            pc_q <= pc_next;
            fetch_addr <= pc_next;
            working_q <= w_d;
            status_q <= status_d;
            pointer0_q <= p0_d;
            pointer1_q <= p1_d;
            // cycle counts
            // jump and upper access are summed, but no word sets both, so wait never exceeds one
            wait_q <= {1'b0, flush} + {1'b0, extra};
            stall_q <= flush | extra;
            // no overflow check: a wrapped push overwrites the oldest entry
            if (push)
            begin
               stack_q[sp_q] <= pc_inc;
               sp_q <= sp_q + 4'h1;
            end
            if (pop)
               sp_q <= sp_q - 4'h1;
            if (op == `OPW_SLEEP)
               standby_q <= 1'b1;
            if (op == `OPW_RESET)
               soft_reset_q <= 1'b1;
            if (op == `OPW_OPTION)
               option_q <= working_q;
            if ((op & `OPM_DIR) == `OPW_DIR && op[2:0] >= 3'h5)
            begin
               dir_sel_q <= {5'h00, op[2:0]};
               dir_data_q <= working_q;
               dir_we_q <= 1'b1;
            end
         end
      end
   end
endmodule

// [verification/mem_model.sv]
// Purpose: program and data memory beside the decoder
// Assumes: all reads answer in the same cycle
// Notes: data and file contents are fixed patterns, so expectations stay cheap
`timescale 1ns/100ps
module mem_model
(
   // program side
   input wire [14:0] fetch_addr,
   output wire [13:0] instr_word,
   // data side
   input wire [15:0] data_addr,
   output wire [7:0] data_rdata,
   input wire [6:0] file_addr,
   output wire [7:0] file_rdata
);
   reg [13:0] rom [0:127];
   integer i;
   initial
   begin
      for (i = 0; i < 128; i = i + 1)
         rom[i] = 14'h0000;
   end
   // beyond the image every word is a no-op
   assign instr_word = (fetch_addr < 15'h0080) ? rom[fetch_addr[6:0]] : 14'h0000;
   assign data_rdata = data_addr[7:0] ^ 8'hA5;
   assign file_rdata = {1'b0, file_addr} ^ 8'hC3;
endmodule

// [verification/op_checker.sv]
// Purpose: port checks for the opcode decoder
// Assumes: stall_q low marks a cycle that executes a word
// Notes: bound from the bench top
`timescale 1ns/100ps
`include "op_decoder_defines.vh"
module op_checker
#(parameter PC_W = 15)
(
   // clock and reset
   input wire core_clk,
   input wire reset_n,
   // memories
   input wire [PC_W-1:0] fetch_addr,
   input wire [13:0] instr_word,
   input wire [15:0] data_addr,
   input wire [7:0] file_rdata,
   input wire [7:0] file_wdata,
   input wire file_we,
   // state
   input wire [7:0] working_q,
   input wire [7:0] status_q,
   input wire [15:0] pointer0_q,
   input wire standby_q,
   input wire stall_q
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);
   wire run = !stall_q;
   wire [13:0] w = instr_word;
   sequence filler;
      stall_q ##1 !stall_q;
   endsequence
   a_wreg_jump:
   assert property (run && w == `OPW_BRANCH_W |=> fetch_addr ==
      PC_W'($past(fetch_addr) + 16'h1 + $past(working_q)) ##0 filler)
      else $error("branch by working register");
   a_rel_jump:
   assert property (run && (w & `OPM_REL) == `OPW_REL |=> fetch_addr == PC_W'($past(fetch_addr)
      + 16'h1 + {{7{$past(w[8])}}, $past(w[8:0])}) ##0 filler) else $error("relative branch");
   a_litret_load:
   assert property (run && (w & `OPM_LIT) == `OPW_RET_LIT |=> working_q == $past(w[7:0])
      ##0 filler) else $error("return with literal");
   a_sleep_flags:
   assert property (run && w == `OPW_SLEEP |=> standby_q && status_q[`STAT_TMOUT]
      && !status_q[`STAT_PWRDN] && !stall_q) else $error("sleep");
   a_mod_step:
   assert property (run && (w & `OPM_MOD) == `OPW_MOD && !w[2] |=> pointer0_q ==
      ($past(w[0]) ? $past(pointer0_q) - 16'h0001 : $past(pointer0_q) + 16'h0001))
      else $error("modifier step");
   a_ptr_add:
   assert property (run && (w & `OPM_PTR_ADD) == `OPW_PTR_ADD && !w[6] |=> pointer0_q ==
      $past(pointer0_q) + {{10{$past(w[5])}}, $past(w[5:0])} && $stable(status_q))
      else $error("pointer add");
   a_extra_slot:
   assert property (run && w[13:8] == 6'h3F && data_addr[15] |=> stall_q) else $error("extra");
   a_add_flags:
   assert property (run && (w & `OPM_LIT) == `OPW_ADD_LIT |=> {status_q[`STAT_C], working_q}
      == $past(working_q) + $past(w[7:0]) && status_q[`STAT_Z] == (working_q == 8'h00)
      && status_q[`STAT_DC] == ($past(working_q[3:0]) + $past(w[3:0]) > 5'h0F))
      else $error("add");
   a_reg_and:
   assert property (file_we |-> (w & 14'h3F80) == 14'h0580
      && file_wdata == (working_q & file_rdata) ##1 $stable(working_q)) else $error("and");
endmodule

// [verification/tb.sv]
// Purpose: self-checking bench for the opcode decoder
// Assumes: one program image runs straight through every scenario
// Notes: words are loaded just ahead of the program counter
`timescale 1ns/100ps
module tb;
   reg core_clk = 1'b0;
   reg reset_n = 1'b0;
   wire [14:0] fetch_addr;
   wire [13:0] instr_word;
   wire [15:0] data_addr, pointer0_q, pointer1_q;
   wire [7:0] data_wdata, data_rdata, file_wdata, file_rdata, working_q, status_q;
   wire [7:0] option_q, dir_sel_q, dir_data_q;
   wire [6:0] file_addr;
   wire data_we, file_we, dir_we_q, standby_q, soft_reset_q, stall_q;
   reg [15:0] wr_a;
   reg [7:0] wr_d, fw_d;
   integer n, n_fail = 0;
   integer comparisons = 0;
   integer dw_n = 0;
   always #25 core_clk = ~core_clk;
   control_and_indirect_op_decoder dut_u (.core_clk, .reset_n, .fetch_addr, .instr_word,
      .data_addr, .data_wdata, .data_we, .data_rdata, .file_addr, .file_wdata, .file_we,
      .file_rdata, .working_q, .status_q, .option_q, .dir_sel_q, .dir_data_q, .dir_we_q,
      .standby_q, .soft_reset_q, .pointer0_q, .pointer1_q, .stall_q);
   mem_model mem_u (.fetch_addr, .instr_word, .data_addr, .data_rdata, .file_addr, .file_rdata);
   // strobes stand one cycle only, so latch them
   always @(posedge core_clk)
   begin
      if (data_we === 1'b1)
      begin
         wr_a <= data_addr;
         wr_d <= data_wdata;
      end
      if (file_we === 1'b1)
         fw_d <= file_wdata;
      if (dir_we_q === 1'b1)
         dw_n <= dw_n + 1;
   end
   task final_report;
      begin
         $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
         if (n_fail == 0 && comparisons > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp)
         begin
            n_fail = n_fail + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task put(input [6:0] a, input [13:0] wd);
      mem_u.rom[a] = wd;
   endtask
   // counts edges until the word at a is about to execute
   task run_to(input [14:0] a);
      begin
         n = 0;
         while (!(fetch_addr === a && stall_q === 1'b0) && n < 200)
         begin
            @(posedge core_clk);
            #1;
            n = n + 1;
         end
         if (n == 200)
         begin
            n_fail = n_fail + 1;
            final_report;
         end
      end
   endtask
   task sc_literal;
      begin
         put(0, 14'h3EC5);
         put(1, 14'h3E4B);
         put(2, 14'h390F);
         run_to(3);
         chk(n, 3);
         chk({working_q, status_q}, 16'h001F);
      end
   endtask
   task sc_pointer;
      begin
         put(3, 14'h313F);
         put(4, 14'h315F);
         put(5, 14'h3F41);
         run_to(6);
         chk(n, 3);
         chk(pointer0_q, 16'hFFFF);
         chk(pointer1_q, 16'h001F);
         chk({working_q, status_q}, 16'h851B);
      end
   endtask
   task sc_indirect;
      begin
         put(6, 14'h3F00);
         put(7, 14'h3FC2);
         run_to(8);
         chk(n, 3);
         chk({working_q, status_q}, 16'h5A1B);
         chk(wr_a, 16'h0021);
         chk({wr_d, status_q}, 16'h5A1B);
      end
   endtask
   task sc_flow;
      begin
         put(8, 14'h000B);
         put(7'h63, 14'h33A6);
         run_to(10);
         chk(n, 4);
         put(10, 14'h000A);
         put(7'h5A, 14'h3477);
         run_to(11);
         chk(n, 4);
         chk(working_q, 16'h0077);
      end
   endtask
   task sc_inherent;
      begin
         put(11, 14'h0062);
         put(12, 14'h0065);
         put(13, 14'h0592);
         put(14, 14'h0512);
         run_to(15);
         chk({option_q, dir_sel_q}, 16'h7705);
         chk({dir_data_q, fw_d}, 16'h7751);
         chk({working_q, status_q}, 16'h511B);
         chk(dw_n, 1);
         put(15, 14'h0063);
         repeat (2) @(posedge core_clk);
         #1;
         chk({7'h00, standby_q, status_q}, 16'h0113);
      end
   endtask
   task sc_modifier;
      begin
         put(17, 14'h0010);
         put(18, 14'h001F);
         put(19, 14'h0015);
         run_to(20);
         chk(n, 3);
         chk(pointer0_q, 16'h0000);
         chk(pointer1_q, 16'h001D);
         chk({working_q, status_q}, 16'hB813);
         chk({wr_d, wr_a[7:0]}, 16'hA51F);
      end
   endtask
   task sc_call;
      begin
         put(20, 14'h2070);
         put(7'h70, 14'h0064);
         put(7'h71, 14'h0008);
         run_to(21);
         chk(n, 5);
         chk({8'h00, status_q}, 16'h001B);
      end
   endtask
   initial
   begin
      repeat (20) @(posedge core_clk);
      reset_n <= 1'b1;
      #1;
      chk({working_q, status_q}, 16'h0018);
      chk({option_q, pointer0_q[7:0]}, 16'hFF00);
      sc_literal;
      sc_pointer;
      sc_indirect;
      sc_flow;
      sc_inherent;
      sc_modifier;
      sc_call;
      final_report;
   end
endmodule
bind control_and_indirect_op_decoder op_checker #(.PC_W(PC_W)) chk_u (.core_clk, .reset_n,
   .fetch_addr, .instr_word, .data_addr, .file_rdata, .file_wdata, .file_we, .working_q,
   .status_q, .pointer0_q, .standby_q, .stall_q);
